/* File: verilog/cam_ctl.sv */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "cam_map.svh"

// Function
// - reference select bits 15:14, default 10b
// - pixel reset level 13:12; never write 2,3
// - write pixel reset level 01b after startup
// - ramp offset bits 11:10, default 01b
// - inverse gain bits 9:8, code3 gives gain0
// - rows in reset 7:0; never above 248
// - zero rows means soft reset mode
// - downstream bits xored with clock; receiver undoes
// - receiver oversamples downstream line fast enough; here pclk is far below the advised rate
// - send code 1001, address 0, data MSB-first
// - sample rising edge, clock at most 2.5 MHz
// - commit on correct code after 24 edges
// - release upstream drivers before sensor transmits

module cam_ctl
    import cam_pkg::*;
#(
    parameter int SCL_HALF = `CAM_SCL_HALF_CYC,
    parameter int RX_BLANK = 7
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    cam_link_if.ctl          link
);
    logic [15:0] shadow_ff;
    logic        pend_ff;
    logic [31:0] prdata_ff;
    cam_ser_st_t st_ff;
    logic [15:0] cnt_ff;
    logic [4:0]  bit_ff;
    logic [23:0] frame_ff;
    logic        scl_ff;
    logic        oe_ff;
    logic        rx_s;
    logic        rx_d_ff;
    logic [7:0]  blank_ff;
    logic [15:0] rx_sr_ff;
    logic [7:0]  rx_cnt_ff;
    logic        hit;
    logic [31:0] rd_val;
    wire         setup;
    wire         acc;
    wire         wr;
    wire         start;
    wire         phase_end;
    wire         rx_edge;

    ////////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, read data latched in the setup cycle

    assign setup   = psel & ~penable;
    assign acc     = psel & penable;
    assign wr      = acc & pwrite & hit;
    assign pready  = acc;
    assign pslverr = acc & ~hit;
    assign prdata  = prdata_ff;

    // address decode and read mux
    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            `CAM_OFF_SHADOW: rd_val = {16'h0000, shadow_ff};
            `CAM_OFF_CMD:    rd_val = 32'h0000_0000;
            `CAM_OFF_STATUS: rd_val = {16'h0000, rx_cnt_ff, 6'h00, pend_ff, oe_ff};
            `CAM_OFF_RXDATA: rd_val = {16'h0000, rx_sr_ff};
            default:         hit    = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)   prdata_ff <= 32'h0000_0000;
        else if (setup) prdata_ff <= rd_val;
    end

    ////////////////////////////////////////////////////////////////////////
    // shadow copy: the sensor cannot be read back, so the whole word is
    // kept here and every send rewrites all fields

    // forbidden codes are clamped rather than refused, so a bad write
    // still leaves a usable value in place
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_ff <= `CAM_SHADOW_RST;
        end else if (wr && paddr == `CAM_OFF_SHADOW) begin
            shadow_ff[15:14] <= pwdata[15:14];
            shadow_ff[11:8]  <= pwdata[11:8];
            shadow_ff[`CAM_PIXRST_F] <= (pwdata[13:12] > `CAM_PIXRST_MAX) ?
                                        `CAM_PIXRST_MAX : pwdata[13:12];
            shadow_ff[`CAM_ROWS_F]   <= (pwdata[7:0] > `CAM_ROWS_MAX) ?
                                        `CAM_ROWS_MAX : pwdata[7:0];
        end
    end

    // send request; set at reset so the safe word goes out first,
    // and a new request in the start cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= 1'b1;
        end else if (wr && paddr == `CAM_OFF_CMD && pwdata[0]) begin
            pend_ff <= 1'b1;
        end else if (start) begin
            pend_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // upstream serial engine: 24 clocks, data changed on the falling edge

    assign start     = (st_ff == CAM_SER_IDLE) && pend_ff;
    assign phase_end = (cnt_ff == 16'(SCL_HALF - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff    <= CAM_SER_IDLE;
            cnt_ff   <= '0;
            bit_ff   <= '0;
            frame_ff <= '0;
            scl_ff   <= 1'b0;
            oe_ff    <= 1'b0;
        end else begin
            unique case (st_ff)
                CAM_SER_IDLE: begin
                    if (pend_ff) begin
                        // code, address, data, then one closing clock
                        frame_ff <= {`CAM_UPD_CODE, `CAM_REG_ADDR,
                                     shadow_ff, 1'b0};
                        cnt_ff   <= '0;
                        bit_ff   <= '0;
                        scl_ff   <= 1'b0;
                        oe_ff    <= 1'b1;
                        st_ff    <= CAM_SER_LOW;
                    end
                end
                CAM_SER_LOW: begin
                    if (phase_end) begin
                        cnt_ff <= '0;
                        scl_ff <= 1'b1;
                        st_ff  <= CAM_SER_HIGH;
                    end else begin
                        cnt_ff <= cnt_ff + 16'h1;
                    end
                end
                CAM_SER_HIGH: begin
                    if (!phase_end) begin
                        cnt_ff <= cnt_ff + 16'h1;
                    end else if (bit_ff == 5'(`CAM_FRAME_EDGES - 1)) begin
                        cnt_ff <= '0;
                        scl_ff <= 1'b0;
                        oe_ff  <= 1'b0;
                        st_ff  <= CAM_SER_IDLE;
                    end else begin
                        cnt_ff   <= '0;
                        scl_ff   <= 1'b0;
                        frame_ff <= {frame_ff[22:0], 1'b0};
                        bit_ff   <= bit_ff + 5'h1;
                        st_ff    <= CAM_SER_LOW;
                    end
                end
            endcase
        end
    end

    // drivers are released as soon as the frame ends, so a sensor that
    // resumes on its own timing never meets a driven line
    assign link.scl_o      = scl_ff;
    assign link.scl_oe     = oe_ff;
    assign link.sda_ctl_o  = frame_ff[23];
    assign link.sda_ctl_oe = oe_ff;

    ////////////////////////////////////////////////////////////////////////
    // downstream decode: each bit has a transition mid-cell; the level
    // after it is the bit. edges near a cell boundary are blanked.
    // limitation: pclk is far below the advised oversampling rate, so
    // the sensor cell must last several pclk cycles

    cam_sync #(.W(1)) u_rx_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (link.sda),
        .q     (rx_s)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rx_d_ff <= 1'b0;
        else          rx_d_ff <= rx_s;
    end

    // own traffic on the shared line is not decoded
    assign rx_edge = (rx_s ^ rx_d_ff) & ~oe_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blank_ff  <= '0;
            rx_sr_ff  <= '0;
            rx_cnt_ff <= '0;
        end else if (rx_edge && blank_ff == 8'h00) begin
            blank_ff  <= 8'(RX_BLANK);
            rx_sr_ff  <= {rx_sr_ff[14:0], rx_s};
            rx_cnt_ff <= rx_cnt_ff + 8'h1;
        end else if (blank_ff != 8'h00) begin
            blank_ff  <= blank_ff - 8'h1;
        end
    end
endmodule : cam_ctl

/* File: verilog/cam_map.svh */
`ifndef CAM_MAP_SVH
`define CAM_MAP_SVH

// configuration word fields
`define CAM_VREF_F        15:14
`define CAM_PIXRST_F      13:12
`define CAM_OFFSET_F      11:10
`define CAM_INVGAIN_F     9:8
`define CAM_ROWS_F        7:0

// sensor power-on value and the controller's safe start value
`define CAM_CFG_RST       16'ha601
`define CAM_SHADOW_RST    16'h9601

// serial write frame
`define CAM_UPD_CODE      4'h9
`define CAM_REG_ADDR      3'h0
`define CAM_FRAME_EDGES   24
`define CAM_ROWS_MAX      8'hf8
`define CAM_PIXRST_MAX    2'h1
`define CAM_WORD_BITS     12

// controller register offsets
`define CAM_OFF_SHADOW    8'h00
`define CAM_OFF_CMD       8'h04
`define CAM_OFF_STATUS    8'h08
`define CAM_OFF_RXDATA    8'h0c

// serial clock timing
`define CAM_PCLK_MHZ      100
`define CAM_SCL_HALF_NS   200
`define CAM_SCL_HALF_CYC  ((`CAM_SCL_HALF_NS * `CAM_PCLK_MHZ + 999) / 1000)

`endif

/* File: verilog/cam_pkg.sv */
package cam_pkg;

    // upstream serial engine of the controller
    typedef enum logic [1:0] {
        CAM_SER_IDLE,
        CAM_SER_LOW,
        CAM_SER_HIGH
    } cam_ser_st_t;

endpackage : cam_pkg

/* File: verilog/cam_link_if.sv */
`timescale 1ns/1ps

interface cam_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_ctl_o;
    logic sda_ctl_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic scl;
    logic sda;

    // wire levels; an undriven line reads low
    assign scl = scl_oe ? scl_o : 1'b0;
    assign sda = sda_ctl_oe ? sda_ctl_o : (sda_dev_oe ? sda_dev_o : 1'b0);

    modport ctl (output scl_o, output scl_oe, output sda_ctl_o, output sda_ctl_oe,
                 input sda);
    modport dev (output sda_dev_o, output sda_dev_oe, input scl, input sda);
endinterface : cam_link_if

/* File: verilog/cam_sync.sv */
`timescale 1ns/1ps

module cam_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // two stages; only the second stage is read by anyone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule : cam_sync

/* File: verilog/cam_dev.sv */
`timescale 1ns/1ps
`include "cam_map.svh"

module cam_dev
    import cam_pkg::*;
#(
    parameter int HALF_CYC = 4
) (
    input  wire logic       link_clk,
    input  wire logic       dev_rst_n,
    input  wire logic       tx_start,
    input  wire logic [9:0] tx_word,
    output logic            tx_ready,
    output logic [1:0]      vref_cds_sel,
    output logic [1:0]      pixel_reset_level,
    output logic [1:0]      ramp_offset,
    output logic [1:0]      ramp_gain,
    output logic [7:0]      rows_in_reset,
    output logic            soft_reset_mode,
    output logic            cfg_update,
    cam_link_if.dev         link
);
    logic [1:0]  pin_s;
    logic        scl_d_ff;
    logic [22:0] sr_ff;
    logic [4:0]  ecnt_ff;
    logic        act_ff;
    logic [15:0] cfg_ff;
    logic        upd_ff;
    logic [11:0] word_ff;
    logic [3:0]  bit_ff;
    logic [7:0]  hcnt_ff;
    logic        ph_ff;
    logic        busy_ff;
    logic        line_ff;
    wire         scl_rise;
    wire         last_edge;
    wire         half_end;

    ////////////////////////////////////////////////////////////////////////
    // upstream receive

    cam_sync #(.W(2)) u_sync (
        .clk   (link_clk),
        .rst_n (dev_rst_n),
        .d     ({link.scl, link.sda}),
        .q     (pin_s)
    );

    // sample on the rising serial clock; ignored while we drive the line
    always_ff @(posedge link_clk or negedge dev_rst_n) begin
        if (!dev_rst_n) scl_d_ff <= 1'b0;
        else            scl_d_ff <= pin_s[1];
    end
    assign scl_rise  = pin_s[1] & ~scl_d_ff & ~busy_ff;
    assign last_edge = act_ff && (ecnt_ff == 5'(`CAM_FRAME_EDGES - 1));

    // counting starts at the first high bit; clears at the 24th edge
    always_ff @(posedge link_clk or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            sr_ff   <= '0;
            ecnt_ff <= '0;
            act_ff  <= 1'b0;
        end else if (scl_rise) begin
            if (last_edge) begin
                sr_ff   <= '0;
                ecnt_ff <= '0;
                act_ff  <= 1'b0;
            end else if (act_ff) begin
                sr_ff   <= {sr_ff[21:0], pin_s[0]};
                ecnt_ff <= ecnt_ff + 5'h1;
            end else if (pin_s[0]) begin
                sr_ff   <= 23'h000001;
                ecnt_ff <= 5'h1;
                act_ff  <= 1'b1;
            end
        end
    end

    // only a correct update code commits the data bits
    always_ff @(posedge link_clk or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            cfg_ff <= `CAM_CFG_RST;
            upd_ff <= 1'b0;
        end else begin
            upd_ff <= 1'b0;
            if (scl_rise && last_edge && sr_ff[22:19] == `CAM_UPD_CODE) begin
                cfg_ff <= sr_ff[15:0];
                upd_ff <= 1'b1;
            end
        end
    end

    // field decode; a bad code is stored as written, not repaired
    assign vref_cds_sel      = cfg_ff[`CAM_VREF_F];
    assign pixel_reset_level = cfg_ff[`CAM_PIXRST_F];
    assign ramp_offset       = cfg_ff[`CAM_OFFSET_F];
    assign ramp_gain         = 2'h3 - cfg_ff[`CAM_INVGAIN_F];
    assign rows_in_reset     = cfg_ff[`CAM_ROWS_F];
    assign soft_reset_mode   = (cfg_ff[`CAM_ROWS_F] == 8'h00);
    assign cfg_update        = upd_ff;

    ////////////////////////////////////////////////////////////////////////
    // downstream transmit: start bit, 10 data bits, stop bit, each bit
    // sent as two halves xored with the data clock phase

    assign tx_ready = ~busy_ff;
    assign half_end = (hcnt_ff == 8'(HALF_CYC - 1));

    always_ff @(posedge link_clk or negedge dev_rst_n) begin
        if (!dev_rst_n) begin
            word_ff <= '0;
            bit_ff  <= '0;
            hcnt_ff <= '0;
            ph_ff   <= 1'b0;
            busy_ff <= 1'b0;
            line_ff <= 1'b0;
        end else if (!busy_ff) begin
            if (tx_start) begin
                word_ff <= {1'b1, tx_word, 1'b0};
                bit_ff  <= '0;
                hcnt_ff <= '0;
                ph_ff   <= 1'b1;
                busy_ff <= 1'b1;
                line_ff <= 1'b1 ^ 1'b1;
            end
        end else if (!half_end) begin
            hcnt_ff <= hcnt_ff + 8'h1;
        end else begin
            hcnt_ff <= '0;
            if (ph_ff) begin
                ph_ff   <= 1'b0;
                line_ff <= word_ff[11] ^ 1'b0;
            end else if (bit_ff == 4'(`CAM_WORD_BITS - 1)) begin
                busy_ff <= 1'b0;
                line_ff <= 1'b0;
            end else begin
                word_ff <= {word_ff[10:0], 1'b0};
                bit_ff  <= bit_ff + 4'h1;
                ph_ff   <= 1'b1;
                line_ff <= word_ff[10] ^ 1'b1;
            end
        end
    end

    assign link.sda_dev_o  = line_ff;
    assign link.sda_dev_oe = busy_ff;
endmodule : cam_dev

/* File: verif/cam_link_props.sv */
`timescale 1ns/1ps

module cam_link_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic link_clk,
    input wire logic dev_rst_n,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_ctl_o,
    input wire logic sda_ctl_oe,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic scl,
    input wire logic sda
);
    logic [5:0] rise_cnt_ff;
    logic       scl_d_ff;
    logic [7:0] tx_cnt_ff;

    // serial clock rises within one frame; idle drivers restart the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_cnt_ff <= 6'h00;
            scl_d_ff    <= 1'b0;
        end else begin
            scl_d_ff <= scl;
            if (!scl_oe)
                rise_cnt_ff <= 6'h00;
            else if (scl && !scl_d_ff)
                rise_cnt_ff <= rise_cnt_ff + 6'h01;
        end
    end

    // length of one downstream word in link clocks
    always_ff @(posedge link_clk or negedge dev_rst_n) begin
        if (!dev_rst_n)
            tx_cnt_ff <= 8'h00;
        else if (!sda_dev_oe)
            tx_cnt_ff <= 8'h00;
        else
            tx_cnt_ff <= tx_cnt_ff + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////
    // repetition counts assume the bench's half period of 4 clocks
    a_no_contention: assert property (@(posedge pclk) disable iff (!presetn)
        !(sda_ctl_oe && sda_dev_oe)) else $error("both ends drive the data line");
    a_frame_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sda_ctl_oe) |-> sda_ctl_o && !scl_o && scl_oe) else $error("bad frame start");
    a_scl_high_len: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(scl_o) |-> scl_o [*4]) else $error("serial clock high too short");
    a_scl_low_len: assert property (@(posedge pclk) disable iff (!presetn)
        scl_oe && $fell(scl_o) |-> (!scl_o) [*4]) else $error("serial clock low too short");
    a_sda_hold: assert property (@(posedge pclk) disable iff (!presetn)
        scl_oe && scl_o |-> $stable(sda_ctl_o)) else $error("data moved while clock high");
    a_frame_edges: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(scl_oe) |-> rise_cnt_ff == 6'h18) else $error("frame not 24 clocks");
    a_release_both: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(scl_oe) |-> ##[0:1] !sda_ctl_oe) else $error("data driver not released");
    a_dev_start: assert property (@(posedge link_clk) disable iff (!dev_rst_n)
        $rose(sda_dev_oe) |-> (sda_dev_oe && !sda_dev_o) [*4] ##1 sda_dev_o)
        else $error("start bit not encoded");
    a_dev_word_len: assert property (@(posedge link_clk) disable iff (!dev_rst_n)
        $fell(sda_dev_oe) |-> tx_cnt_ff == 8'h60) else $error("word length wrong");
    a_dev_stop: assert property (@(posedge link_clk) disable iff (!dev_rst_n)
        $fell(sda_dev_oe) |-> !$past(sda_dev_o) && $past(sda_dev_o, 5))
        else $error("stop bit not encoded");

    c_up_frame: cover property (@(posedge pclk) disable iff (!presetn) $fell(scl_oe));
    c_dn_word: cover property (@(posedge link_clk) disable iff (!dev_rst_n) $fell(sda_dev_oe));
    c_start: cover property (@(posedge pclk) disable iff (!presetn) $rose(sda_ctl_oe));
endmodule : cam_link_props

/* File: verif/test_camera_config_register.sv */
`timescale 1ns/1ps
`include "cam_map.svh"

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module test_camera_config_register;
    logic        pclk = 1'b0;
    logic        link_clk = 1'b0;
    logic        presetn = 1'b0;
    logic        dev_rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, tx_ready, soft_reset_mode, cfg_update;
    logic        tx_start = 1'b0;
    logic [9:0]  tx_word = 10'h000;
    logic [1:0]  vref_cds_sel, pixel_reset_level, ramp_offset, ramp_gain;
    logic [7:0]  rows_in_reset;
    logic [23:0] wire_bits;
    int          upd_cnt = 0;
    integer      seed;
    int          error_cnt = 0, checked = 0, cycles = 0;
    logic [15:0] corner [6] = '{16'h0000, 16'h5555, 16'haaaa, 16'hffff, 16'h55f9, 16'haaf8};

    always #5 pclk = ~pclk;
    // 12 ns against 10 ns: the rising edges of the two clocks never coincide
    always #6 link_clk = ~link_clk;

    cam_link_if lnk ();
    cam_ctl #(.SCL_HALF(4)) i_cam_ctl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .link(lnk));
    cam_dev i_cam_dev (.link_clk, .dev_rst_n, .tx_start, .tx_word, .tx_ready, .vref_cds_sel,
        .pixel_reset_level, .ramp_offset, .ramp_gain, .rows_in_reset, .soft_reset_mode,
        .cfg_update, .link(lnk));
    cam_link_props i_props (.pclk, .presetn, .link_clk, .dev_rst_n, .scl_o(lnk.scl_o),
        .scl_oe(lnk.scl_oe), .sda_ctl_o(lnk.sda_ctl_o), .sda_ctl_oe(lnk.sda_ctl_oe),
        .sda_dev_o(lnk.sda_dev_o), .sda_dev_oe(lnk.sda_dev_oe), .scl(lnk.scl), .sda(lnk.sda));

    // what the device sees on the wire, bit by bit
    always @(posedge lnk.scl) if (lnk.scl_oe) wire_bits <= {wire_bits[22:0], lnk.sda};
    always @(posedge link_clk) if (cfg_update === 1'b1) upd_cnt <= upd_cnt + 1;
    // hang guard: a full run needs well under this
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            error_cnt++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // forbidden codes are pulled back to the nearest legal value
    function automatic logic [15:0] clamp(input logic [15:0] v);
        logic [15:0] r;
        r = v;
        if (r[13:12] > 2'h1) r[13:12] = 2'h1;
        if (r[7:0] > 8'hf8) r[7:0] = 8'hf8;
        return r;
    endfunction : clamp

    task automatic commit(input int u, input logic [15:0] e);
        logic [31:0] rd;
        logic        err;
        int          n;
        do apb(1'b0, `CAM_OFF_STATUS, 32'h0, rd, err); while (rd[1:0] !== 2'h0);
        for (n = 0; n < 100 && upd_cnt == u; n++) @(posedge pclk);
        `CHK(upd_cnt, u + 1)
        `CHK(wire_bits, {`CAM_UPD_CODE, `CAM_REG_ADDR, e, 1'b0})
        `CHK(vref_cds_sel, e[15:14])
        `CHK(pixel_reset_level, e[13:12])
        `CHK(ramp_offset, e[11:10])
        `CHK(ramp_gain, 2'h3 - e[9:8])
        `CHK(rows_in_reset, e[7:0])
        `CHK(soft_reset_mode, e[7:0] == 8'h00)
        $display("config %h committed", e);
    endtask : commit

    task automatic send(input logic [15:0] v);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, `CAM_OFF_SHADOW, {16'h0, v}, rd, err);
        apb(1'b0, `CAM_OFF_SHADOW, 32'h0, rd, err);
        `CHK(rd, {16'h0, clamp(v)})
        apb(1'b1, `CAM_OFF_CMD, 32'h1, rd, err);
        commit(upd_cnt, clamp(v));
    endtask : send

    task automatic tx(input logic [9:0] w);
        logic [31:0] rd;
        logic        err;
        logic [7:0]  c0;
        apb(1'b0, `CAM_OFF_STATUS, 32'h0, rd, err);
        c0 = rd[15:8];
        @(posedge link_clk);
        tx_word  <= w;
        tx_start <= 1'b1;
        @(posedge link_clk);
        tx_start <= 1'b0;
        do @(posedge link_clk); while (tx_ready !== 1'b1);
        repeat (20) @(posedge pclk);
        apb(1'b0, `CAM_OFF_RXDATA, 32'h0, rd, err);
        `CHK(rd[11:0], {1'b1, w, 1'b0})
        apb(1'b0, `CAM_OFF_STATUS, 32'h0, rd, err);
        `CHK(rd[15:8], c0 + 8'h0c)
        $display("word %h received", w);
    endtask : tx

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] rd;
        logic        err;
        seed = 69873;
        repeat (2) @(posedge pclk);
        @(posedge link_clk) dev_rst_n <= 1'b1;
        `CHK(rows_in_reset, 8'h01)
        `CHK({vref_cds_sel, pixel_reset_level, ramp_offset}, 6'h29)
        `CHK(ramp_gain, 2'h1)
        $display("reset values checked");
        @(posedge pclk) presetn <= 1'b1;
        commit(0, `CAM_SHADOW_RST);
        foreach (corner[i]) send(corner[i]);
        for (int i = 0; i < 6; i++) begin
            send(16'($random(seed)));
            tx(10'($random(seed)));
        end
        tx(10'h18d);
        tx(10'h000);
        tx(10'h3ff);
        // controller reset alone in mid-run: the safe word must go out again
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        commit(upd_cnt, `CAM_SHADOW_RST);
        apb(1'b0, 8'h10, 32'h0, rd, err);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b0, `CAM_OFF_CMD, 32'h0, rd, err);
        `CHK({err, rd}, 33'h0)
        $display("register map checked");
        close_out();
    end
endmodule : test_camera_config_register
